// ==== common/aser_defs.svh ====
/*
  Offsets, field positions and timing counts for the async serial unit.
  Assumes a byte-wide register port with 16-bit addresses.
*/
`ifndef ASER_DEFS_SVH
`define ASER_DEFS_SVH

// Register addresses
`define ASER_OFS_CTL1 16'h102c
`define ASER_OFS_CTL2 16'h102d
`define ASER_OFS_STAT 16'h102e
`define ASER_OFS_DATA 16'h102f

// Control one fields
`define ASER_C1_RX9 7
`define ASER_C1_TX9 6
`define ASER_C1_LEN 4
`define ASER_C1_WAKE 3

// Control two fields, reset value
`define ASER_C2_TIE 7
`define ASER_C2_TX_COMPLETE_IRQ_ENABLE 6
`define ASER_C2_RIE 5
`define ASER_C2_IDLE_IRQ_ENABLE 4
`define ASER_C2_TE 3
`define ASER_C2_RE 2
`define ASER_C2_SLEEP 1
`define ASER_C2_BRK 0
`define ASER_C2_RESET 8'h00

// Status fields
`define ASER_ST_TRANSMIT_EMPTY_FLAG 7
`define ASER_ST_TC 6
`define ASER_ST_RECEIVE_FULL_FLAG 5
`define ASER_ST_IDLE 4
`define ASER_ST_OVR 3
`define ASER_ST_NF 2
`define ASER_ST_FE 1

// Timing: clocks per sample tick, sample ticks per bit, vote points
`define ASER_DIV_DEFAULT 16
`define ASER_PHASE_LAST 4'hf
`define ASER_VOTE_FIRST 4'h7
`define ASER_VOTE_LAST 4'h9

`endif

// ==== common/aser_pkg.sv ====
/*
  Types and shared helpers of the async serial unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package aser_pkg;
  // Receiver states
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } aser_rx_state_t;

  // Transmitter states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_PRE = 2'b01,
    TX_BRK = 2'b10,
    TX_DATA = 2'b11
  } aser_tx_state_t;

  // Bits in one frame: start, 8 or 9 data, stop
  function automatic logic [3:0] aser_frame_bits(input logic nine);
    return nine ? 4'hb : 4'ha;
  endfunction

  // Majority of three samples
  function automatic logic aser_major(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction
endpackage

// ==== common/aser_if.sv ====
/*
  Serial link between the unit and its remote partner.
  Assumes both lines idle high and are driven by one end each.
*/
interface aser_if;
  logic dev_txd; // Unit to partner
  logic far_txd; // Partner to unit

  modport dev(output dev_txd, input far_txd);
  modport far(input dev_txd, output far_txd);
endinterface

// ==== verilog/aser_rx.sv ====
/*
  Oversampling receiver: start detect, three-sample majority vote,
  noise and framing report, idle-line detect.
  Assumes a sample tick at 16 per bit and a line synchronous to clk.
*/
`include "aser_defs.svh"
module aser_rx
  import aser_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic nine,
  input wire logic tick,
  input wire logic rxd,
  output logic done,
  output logic [8:0] data,
  output logic noise,
  output logic frame_err,
  output logic idle
);
  aser_rx_state_t state; // Frame position
  logic [3:0] phase; // Sample slot within a bit
  logic [1:0] samp; // Earlier vote samples
  logic [8:0] shreg; // Data arrives LSB first
  logic [3:0] bitcnt; // Data bits taken
  logic noise_acc; // Any split vote in this frame
  logic [7:0] idle_cnt; // High ticks seen while idle
  logic armed; // Line was active since last idle report
  logic [2:0] votes;
  logic maj;
  logic split;

  assign votes = {samp, rxd};
  assign maj = aser_major(votes);
  assign split = (votes != 3'h0) && (votes != 3'h7);

  // Frame sequencer; vote taken at the middle of each bit
  always_ff @(posedge clk)
  begin
    done <= 1'b0;
    if (rst || !enable)
    begin
      state <= RX_IDLE;
      phase <= 4'h0;
      samp <= 2'h0;
      shreg <= 9'h000;
      bitcnt <= 4'h0;
      noise_acc <= 1'b0;
      data <= 9'h000;
      noise <= 1'b0;
      frame_err <= 1'b0;
    end
    else if (tick)
    begin
      if (state == RX_IDLE)
      begin
        // A low line while idle opens a frame R20
        if (!rxd)
        begin
          state <= RX_START;
          phase <= 4'h1;
          noise_acc <= 1'b0;
          bitcnt <= 4'h0;
        end
      end
      else
      begin
        phase <= phase + 4'h1;
        if (phase >= `ASER_VOTE_FIRST && phase < `ASER_VOTE_LAST)
          samp <= {samp[0], rxd};
        if (phase == `ASER_VOTE_LAST)
        begin
          unique case (state)
            RX_START:
            begin
              // A high vote means a glitch, not a start bit
              state <= maj ? RX_IDLE : RX_DATA;
              noise_acc <= split; // R4
            end
            RX_DATA:
            begin
              shreg <= {maj, shreg[8:1]}; // R20
              noise_acc <= noise_acc | split; // R5
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == aser_frame_bits(nine) - 4'h3)
                state <= RX_STOP;
            end
            RX_STOP:
            begin
              state <= RX_IDLE;
              done <= 1'b1;
              data <= nine ? shreg : {1'b0, shreg[8:1]}; // R10
              noise <= noise_acc | split; // R4 R5
              frame_err <= !maj; // R6
            end
            default:
              state <= RX_IDLE;
          endcase
        end
      end
    end
  end

  // Idle line: one frame time of high after some activity R19
  always_ff @(posedge clk)
  begin
    idle <= 1'b0;
    if (rst || !enable)
    begin
      idle_cnt <= 8'h00;
      armed <= 1'b0;
    end
    else if (state != RX_IDLE || !rxd)
    begin
      idle_cnt <= 8'h00;
      armed <= 1'b1;
    end
    else if (tick && armed)
    begin
      if (idle_cnt == {aser_frame_bits(nine), 4'h0})
      begin
        idle <= 1'b1; // R19
        armed <= 1'b0;
      end
      else
        idle_cnt <= idle_cnt + 8'h01;
    end
  end
endmodule

// ==== verilog/aser_dev.sv ====
/*
  Async serial unit: register port, transmitter, receiver flags.
  Assumes a CPU port with one-cycle strobes and a partner on LINK.
*/
// The strobed register port is this design's own decision.
//
// Contract
// R1 - Full buffer at arrival sets overrun
// R2 - Overrun discards new, keeps held character
// R3 - Overrun clears: status read, then data read
// R4 - Noise on any bit, with receive-full
// R5 - Split vote sets noise; status-data clear
// R6 - Low stop bit sets framing error
// R7 - Framing plus overrun reports only overrun
// R8 - Framing error blocks further buffer loads
// R9 - Data address: read receive, write transmit
// R10 - Length bit picks 8 or 9 bits
// R11 - Wake bit picks idle or address mark
// R12 - Enabled flags raise one shared interrupt
// R13 - Transmitter enable rise queues idle preamble
// R14 - Sleep bit suppresses receiver flags
// R15 - Break write queues break; repeats while set
// R16 - Transmit-empty clears: status read, data write
// R17 - Transmit-complete when idle; same clear sequence
// R18 - Receive-full clears: status read, data read
// R19 - Idle flag once per activity, not asleep
// R20 - Frame: low start, LSB first, high stop
// R21 - Hardware wakes on idle or address mark
// R22 - Interrupt is OR of enabled flags
`include "aser_defs.svh"
module aser_dev
  import aser_pkg::*;
#(
  parameter int DIV = `ASER_DIV_DEFAULT
)
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [7:0] RD_DATA,
  output logic IRQ,
  aser_if.dev LINK
);
  import aser_pkg::*;

  logic [7:0] ctl2; // Enables, sleep, break
  logic len9; // Nine-bit characters
  logic wake_mark; // Address-mark wakeup
  logic tx9; // Ninth bit to send
  logic rx9; // Ninth bit received
  logic [7:0] rx_buf; // Receive data buffer
  logic [7:0] tx_buf; // Transmit data buffer
  logic tx_full; // Transmit buffer holds a character
  logic [7:0] flags; // Status flags, status layout
  logic [7:0] armed; // Flags seen set by a status read
  logic [15:0] div_cnt; // Sample tick divider
  logic tick; // Sample tick, 16 per bit
  logic [3:0] tx_phase; // Bit boundary counter
  aser_tx_state_t tx_state;
  logic [10:0] tx_shift; // Bits still to send
  logic [3:0] tx_cnt; // Bits still to send, count
  logic te_prev; // For enable rise detect
  logic pre_pend; // Preamble queued
  logic brk_pend; // Break queued
  logic txd;
  logic rx_done;
  logic [8:0] rx_data;
  logic rx_noise;
  logic rx_ferr;
  logic rx_idle;
  logic rx_msb;
  logic sleeping;
  logic deliver;
  logic load_rx;
  logic wake_evt;
  logic bit_tick;
  logic tx_quiet;
  logic [7:0] set_f;

  // Port decode
  logic wr_c1;
  logic wr_c2;
  logic wr_dat;
  logic rd_st;
  logic rd_dat;
  assign wr_c1 = WR_EN && ADDR == `ASER_OFS_CTL1;
  assign wr_c2 = WR_EN && ADDR == `ASER_OFS_CTL2;
  assign wr_dat = WR_EN && ADDR == `ASER_OFS_DATA; // R9
  assign rd_st = RD_EN && ADDR == `ASER_OFS_STAT;
  assign rd_dat = RD_EN && ADDR == `ASER_OFS_DATA; // R9

  // Sample tick divider shared by both directions
  always_ff @(posedge SYS_CLK)
  begin
    if (RST || div_cnt == 16'(DIV - 1))
      div_cnt <= 16'h0000;
    else
      div_cnt <= div_cnt + 16'h0001;
    if (RST)
      tx_phase <= 4'h0;
    else if (tick)
      tx_phase <= tx_phase + 4'h1;
  end
  assign tick = (div_cnt == 16'(DIV - 1));
  assign bit_tick = tick && tx_phase == `ASER_PHASE_LAST;

  aser_rx u_rx (
    .clk(SYS_CLK),
    .rst(RST),
    .enable(ctl2[`ASER_C2_RE]),
    .nine(len9),
    .tick(tick),
    .rxd(LINK.far_txd),
    .done(rx_done),
    .data(rx_data),
    .noise(rx_noise),
    .frame_err(rx_ferr),
    .idle(rx_idle)
  );

  // Receive decisions
  assign sleeping = ctl2[`ASER_C2_SLEEP];
  assign rx_msb = len9 ? rx_data[8] : rx_data[7]; // R11
  // Mark character wakes the unit and is itself taken R11 R21
  assign wake_evt = sleeping && ((!wake_mark && rx_idle) || (wake_mark && rx_done && rx_msb)); // R21
  assign deliver = rx_done && (!sleeping || (wake_mark && rx_msb)); // R14
  // Framing error or a full buffer stops the load R2 R8
  assign load_rx = deliver && !flags[`ASER_ST_RECEIVE_FULL_FLAG] && !flags[`ASER_ST_FE];

  // Hardware set terms; set wins over a clear in the same cycle
  always_comb
  begin
    set_f = 8'h00;
    set_f[`ASER_ST_RECEIVE_FULL_FLAG] = load_rx; // R18
    set_f[`ASER_ST_OVR] = deliver && flags[`ASER_ST_RECEIVE_FULL_FLAG]; // R1 R7
    set_f[`ASER_ST_NF] = load_rx && rx_noise; // R4 R5
    set_f[`ASER_ST_FE] = load_rx && rx_ferr; // R6 R7
    set_f[`ASER_ST_IDLE] = rx_idle && !sleeping; // R19 R14
    set_f[`ASER_ST_TC] = tx_quiet; // R17
    set_f[`ASER_ST_TRANSMIT_EMPTY_FLAG] = bit_tick && tx_state == TX_IDLE && tx_full && ctl2[`ASER_C2_TE]
                           && !pre_pend; // R16
  end

  // Status flags: reads clear receive flags, writes clear transmit flags
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      flags <= 8'hc0;
    else
      flags <= set_f | (flags & ~(armed & ({8{rd_dat}} & 8'h3e | {8{wr_dat}} & 8'hc0))); // R3 R16 R17 R18
  end

  // Arming: a status read remembers which flags it saw set
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      armed <= 8'h00;
    else if (rd_st)
      armed <= flags; // R3
    else if (rd_dat)
      armed <= armed & 8'hc1; // R3 R18
    else if (wr_dat)
      armed <= armed & 8'h3f; // R16
  end

  // Control registers; hardware wakeup clears the sleep bit
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      ctl2 <= `ASER_C2_RESET;
      len9 <= 1'b0;
      wake_mark <= 1'b0;
      tx9 <= 1'b0;
    end
    else
    begin
      if (wr_c2)
        ctl2 <= WR_DATA;
      else if (wake_evt)
        ctl2[`ASER_C2_SLEEP] <= 1'b0; // R21
      if (wr_c1)
      begin
        len9 <= WR_DATA[`ASER_C1_LEN]; // R10
        wake_mark <= WR_DATA[`ASER_C1_WAKE]; // R11
        tx9 <= WR_DATA[`ASER_C1_TX9]; // R10
      end
    end
  end

  // Receive buffer keeps its old character on overrun
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      rx_buf <= 8'h00;
      rx9 <= 1'b0;
    end
    else if (load_rx)
    begin
      rx_buf <= rx_data[7:0]; // R2
      rx9 <= rx_data[8]; // R10
    end
  end

  // Transmit buffer, preamble and break queues
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      tx_buf <= 8'h00;
      tx_full <= 1'b0;
      te_prev <= 1'b0;
      pre_pend <= 1'b0;
      brk_pend <= 1'b0;
    end
    else
    begin
      te_prev <= ctl2[`ASER_C2_TE];
      if (wr_dat)
      begin
        tx_buf <= WR_DATA; // R9
        tx_full <= 1'b1;
      end
      else if (set_f[`ASER_ST_TRANSMIT_EMPTY_FLAG])
        tx_full <= 1'b0;
      if (ctl2[`ASER_C2_TE] && !te_prev)
        pre_pend <= 1'b1; // R13
      else if (bit_tick && tx_state == TX_IDLE && ctl2[`ASER_C2_TE])
        pre_pend <= 1'b0;
      if (wr_c2 && WR_DATA[`ASER_C2_BRK])
        brk_pend <= 1'b1; // R15
      else if (tx_state == TX_BRK)
        brk_pend <= 1'b0;
    end
  end

  // Nothing shifting and, with the transmitter enabled, nothing waiting to shift
  assign tx_quiet = tx_state == TX_IDLE && !wr_dat && (!ctl2[`ASER_C2_TE]
                    || (!tx_full && !pre_pend && !brk_pend && !ctl2[`ASER_C2_BRK])); // R17

  // Transmit shifter; new work starts only on a bit boundary
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      tx_state <= TX_IDLE;
      tx_shift <= 11'h7ff;
      tx_cnt <= 4'h0;
      txd <= 1'b1;
    end
    else if (bit_tick)
    begin
      unique case (tx_state)
        TX_IDLE:
        begin
          txd <= 1'b1; // R20
          tx_cnt <= aser_frame_bits(len9);
          if (!ctl2[`ASER_C2_TE])
            tx_state <= TX_IDLE;
          else if (pre_pend)
          begin
            tx_state <= TX_PRE; // R13
            tx_shift <= 11'h7ff;
          end
          else if (tx_full)
          begin
            tx_state <= TX_DATA;
            tx_shift <= {1'b1, len9 ? tx9 : 1'b1, tx_buf, 1'b0}; // R10 R20
          end
          else if (brk_pend || ctl2[`ASER_C2_BRK])
          begin
            tx_state <= TX_BRK; // R15
            tx_shift <= 11'h000;
          end
        end
        TX_PRE, TX_BRK, TX_DATA:
        begin
          if (tx_cnt == 4'h0)
          begin
            tx_state <= TX_IDLE;
            txd <= 1'b1;
          end
          else
          begin
            txd <= tx_shift[0]; // R20
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_cnt <= tx_cnt - 4'h1;
          end
        end
      endcase
    end
  end
  assign LINK.dev_txd = txd;

  // Read data stands in the cycle after the read strobe
  always_ff @(posedge SYS_CLK)
  begin
    if (RST || !RD_EN)
      RD_DATA <= 8'h00;
    else
    begin
      unique case (ADDR)
        `ASER_OFS_CTL1: RD_DATA <= {rx9, tx9, 1'b0, len9, wake_mark, 3'h0};
        `ASER_OFS_CTL2: RD_DATA <= ctl2;
        `ASER_OFS_STAT: RD_DATA <= flags;
        `ASER_OFS_DATA: RD_DATA <= rx_buf; // R9
        default: RD_DATA <= 8'h00;
      endcase
    end
  end

  // Shared interrupt; drops once every enabled flag is clear
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      IRQ <= 1'b0;
    else
      IRQ <= (ctl2[`ASER_C2_TIE] && flags[`ASER_ST_TRANSMIT_EMPTY_FLAG]) || (ctl2[`ASER_C2_TX_COMPLETE_IRQ_ENABLE] && flags[`ASER_ST_TC])
             || (ctl2[`ASER_C2_RIE] && (flags[`ASER_ST_RECEIVE_FULL_FLAG] || flags[`ASER_ST_OVR]))
             || (ctl2[`ASER_C2_IDLE_IRQ_ENABLE] && flags[`ASER_ST_IDLE]); // R12 R22
  end
endmodule

// ==== verilog/aser_far.sv ====
/*
  Remote partner: sends characters from its user port, reports
  characters it receives.
  Assumes the same bit rate and frame length as the unit.
*/
`include "aser_defs.svh"
module aser_far
  import aser_pkg::*;
#(
  parameter int DIV = `ASER_DIV_DEFAULT
)
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic NINE,
  input wire logic [8:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic RX_VALID,
  output logic [8:0] RX_DATA,
  output logic RX_NOISE,
  output logic RX_FRAME_ERR,
  aser_if.far LINK
);
  import aser_pkg::*;

  logic [15:0] div_cnt; // Sample tick divider
  logic tick;
  logic [3:0] phase; // Sixteen ticks per bit
  logic [10:0] shift; // Frame being sent
  logic [3:0] cnt; // Bits left
  logic txd;
  logic rx_idle;

  // Sample tick and bit phase
  always_ff @(posedge SYS_CLK)
  begin
    if (RST || tick)
      div_cnt <= 16'h0000;
    else
      div_cnt <= div_cnt + 16'h0001;
    if (RST)
      phase <= 4'h0;
    else if (tick)
      phase <= phase + 4'h1;
  end
  assign tick = (div_cnt == 16'(DIV - 1));

  // Sender: one frame per accepted character, LSB first
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      shift <= 11'h7ff;
      cnt <= 4'h0;
      txd <= 1'b1;
      TX_READY <= 1'b1;
    end
    else if (TX_VALID && TX_READY)
    begin
      shift <= {1'b1, NINE ? TX_DATA[8] : 1'b1, TX_DATA[7:0], 1'b0}; // R20
      cnt <= aser_frame_bits(NINE);
      TX_READY <= 1'b0;
    end
    else if (tick && phase == `ASER_PHASE_LAST && !TX_READY)
    begin
      if (cnt == 4'h0)
      begin
        txd <= 1'b1;
        TX_READY <= 1'b1;
      end
      else
      begin
        txd <= shift[0]; // R20
        shift <= {1'b1, shift[10:1]};
        cnt <= cnt - 4'h1;
      end
    end
  end
  assign LINK.far_txd = txd;

  aser_rx u_rx (
    .clk(SYS_CLK),
    .rst(RST),
    .enable(1'b1),
    .nine(NINE),
    .tick(tick),
    .rxd(LINK.dev_txd),
    .done(RX_VALID),
    .data(RX_DATA),
    .noise(RX_NOISE),
    .frame_err(RX_FRAME_ERR),
    .idle(rx_idle)
  );
endmodule

// ==== verification/aser_asserts.sv ====
/*
  Checker on the serial link and the register port of the first unit.
  Assumes one clock, synchronous active-high reset, DIV equal to the unit's.
*/
`include "aser_defs.svh"
module aser_asserts #(
  parameter int DIV = 1
)
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] RD_DATA,
  input wire logic IRQ,
  input wire logic dev_txd,
  input wire logic far_txd
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 16 * DIV; // Clocks per bit
  localparam int FRAME = 10 * BIT; // Shortest frame
  logic prev_txd; // Line one cycle ago
  logic seen; // First edge has fixed the bit grid
  int ph; // Phase inside a bit
  int te_age; // Cycles since the transmitter enable rose
  int low_run; // Consecutive low cycles on the line
  logic brk_arm; // Break written, its end not yet seen
  logic [7:0] ctl2_q; // Shadow of control two
  logic [7:0] ctl2_p; // Shadow one cycle late, as the IRQ register sees it
  logic chg;
  logic irq_exp;
  logic wr_c2;
  assign chg = dev_txd != prev_txd;
  assign wr_c2 = WR_EN && ADDR == `ASER_OFS_CTL2;
  // Overrun shares the receive enable, so bit 3 pairs with bit 5
  assign irq_exp = |(RD_DATA[7:4] & ctl2_p[7:4]) | (RD_DATA[3] & ctl2_p[5]);
  // Helper state; sleep may be cleared by hardware, so the shadow is trusted in every bit but bit 1
  always_ff @(posedge SYS_CLK)
  begin
    prev_txd <= dev_txd;
    if (RST)
    begin
      seen <= 1'b0;
      ph <= 0;
      te_age <= 100000;
      low_run <= 0;
      brk_arm <= 1'b0;
      ctl2_q <= 8'h00;
      ctl2_p <= 8'h00;
    end
    else
    begin
      ctl2_p <= ctl2_q;
      if (wr_c2)
        ctl2_q <= WR_DATA;
      low_run <= dev_txd ? 0 : low_run + 1;
      ph <= (chg || ph == BIT - 1) ? 0 : ph + 1;
      if (chg)
        seen <= 1'b1;
      if (wr_c2 && WR_DATA[3] && !ctl2_q[3])
        te_age <= 0;
      else if (te_age < 100000)
        te_age <= te_age + 1;
      if (chg && dev_txd)
        brk_arm <= 1'b0;
      else if (wr_c2 && WR_DATA[0])
        brk_arm <= 1'b1;
    end
  end
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  sequence s_wr_ctl2;
    WR_EN && ADDR == `ASER_OFS_CTL2;
  endsequence
  sequence s_rd_ctl2;
    RD_EN && ADDR == `ASER_OFS_CTL2;
  endsequence
  AST_LINE_IDLE_RESET: assert property ($fell(RST) |-> dev_txd && far_txd)
    else $error("link not idle after reset");
  AST_TX_BIT_GRID: assert property (chg && seen |-> ph == BIT - 1)
    else $error("transmit edge off the bit grid");
  AST_RD_ONE_CYCLE: assert property (RD_DATA != 8'h00 |-> $past(RD_EN))
    else $error("read data outside its cycle");
  AST_IRQ_MATCH: assert property ($past(RD_EN && ADDR == `ASER_OFS_STAT) |-> IRQ == irq_exp)
    else $error("interrupt disagrees with enabled flags");
  AST_IRQ_OFF: assert property (s_wr_ctl2 and WR_DATA[7:4] == 4'h0 |-> ##2 !IRQ)
    else $error("interrupt stays up with enables off");
  AST_CTL2_READBACK: assert property (s_wr_ctl2 ##2 s_rd_ctl2 |=> (RD_DATA & 8'hfd) == ($past(WR_DATA, 3) & 8'hfd))
    else $error("control two readback wrong");
  AST_PREAMBLE: assert property ($fell(dev_txd) |-> te_age >= FRAME)
    else $error("frame started inside the preamble");
  AST_BREAK_LEN: assert property ($rose(dev_txd) && brk_arm |-> low_run >= FRAME)
    else $error("break shorter than a frame");
endmodule

// ==== verification/async_serial_error_and_control_bench.sv ====
/*
  Bench: unit and partner on one link; a second unit on a line driven here for faults.
  Assumes the defines, package, interface and design modules are compiled first.
*/
`include "aser_defs.svh"
module async_serial_error_and_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic nine; logic [8:0] d;} aser_row_t;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1; // Held for ten cycles at start
  logic [15:0] ADDR = 16'h0000;
  logic [7:0] WR_DATA = 8'h00;
  logic WR_EN = 1'b0;
  logic RD_EN = 1'b0;
  logic [7:0] RD_DATA;
  logic [7:0] RD_DATA_B; // Second unit shares the bus strobes
  logic IRQ;
  logic IRQ_B;
  logic NINE = 1'b0;
  logic [8:0] TX_DATA = 9'h000;
  logic TX_VALID = 1'b0;
  logic TX_READY;
  logic RX_VALID;
  logic [8:0] RX_DATA;
  logic RX_NOISE;
  logic RX_FRAME_ERR;
  logic [7:0] rd_a; // Last read, first unit
  logic [7:0] rd_b; // Last read, second unit
  logic [9:0] wf; // Expected frame on the wire
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Ordinary cases, 8-bit first
  aser_row_t rows [4] = '{'{1'b0, 9'h0a5}, '{1'b0, 9'h001}, '{1'b1, 9'h13c}, '{1'b1, 9'h0ff}};
  aser_if link();
  aser_if link_b(); // Line driven by the bench to break the frame rules
  aser_dev #(.DIV(1)) u_aser_dev (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .IRQ(IRQ), .LINK(link.dev));
  aser_dev #(.DIV(1)) u_aser_dev_b (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA_B), .IRQ(IRQ_B), .LINK(link_b.dev));
  aser_far #(.DIV(1)) u_aser_far (.SYS_CLK(SYS_CLK), .RST(RST), .NINE(NINE), .TX_DATA(TX_DATA),
    .TX_VALID(TX_VALID), .TX_READY(TX_READY), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
    .RX_NOISE(RX_NOISE), .RX_FRAME_ERR(RX_FRAME_ERR), .LINK(link.far));
  aser_asserts #(.DIV(1)) u_aser_asserts (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .IRQ(IRQ), .dev_txd(link.dev_txd), .far_txd(link.far_txd));
  // 40 MHz clock
  initial
  begin
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  // Verdict and end of run
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge SYS_CLK)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_test(input string s);
    $display("test %s done at %0t", s, $time);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WR_DATA <= d;
    WR_EN <= 1'b1;
    @(posedge SYS_CLK);
    WR_EN <= 1'b0;
  endtask
  // Read data stand only in the cycle after the read edge
  task automatic rd(input logic [15:0] a);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD_EN <= 1'b1;
    @(posedge SYS_CLK);
    RD_EN <= 1'b0;
    #1;
    rd_a = RD_DATA;
    rd_b = RD_DATA_B;
  endtask
  // Poll status of the first unit until a flag shows, bounded
  task automatic poll(input int idx);
    repeat (400)
    begin
      rd(`ASER_OFS_STAT);
      if (rd_a[idx])
        break;
    end
  endtask
  // Partner request holds until taken
  task automatic far_send(input logic [8:0] d);
    @(posedge SYS_CLK);
    TX_DATA <= d;
    TX_VALID <= 1'b1;
    do @(posedge SYS_CLK); while (!TX_READY);
    TX_VALID <= 1'b0;
  endtask
  task automatic rx_far();
    repeat (3000)
    begin
      @(posedge SYS_CLK);
      if (RX_VALID)
        break;
    end
    #1;
  endtask
  // Hand-made 8-bit frame; a glitch in bit 3 splits the vote
  task automatic line_send(input logic [7:0] d, input logic noisy, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++)
      for (int c = 0; c < 16; c++)
      begin
        @(posedge SYS_CLK);
        link_b.far_txd <= f[i] ^ (noisy && i == 3 && c / 2 == 4);
      end
    @(posedge SYS_CLK);
    link_b.far_txd <= 1'b1;
    repeat (20) @(posedge SYS_CLK);
  endtask
  initial
  begin
    link_b.far_txd = 1'b1;
    repeat (10) @(posedge SYS_CLK);
    RST <= 1'b0;
    wr(`ASER_OFS_CTL2, 8'h0c);
    foreach (rows[i])
    begin
      NINE <= rows[i].nine;
      wr(`ASER_OFS_CTL1, {1'b0, rows[i].d[8], 1'b0, rows[i].nine, 4'h0});
      wr(`ASER_OFS_DATA, rows[i].d[7:0]);
      rx_far();
      chk_val(RX_DATA, rows[i].nine ? rows[i].d : {1'b0, rows[i].d[7:0]});
      chk_val({8'h00, RX_FRAME_ERR}, 9'h000);
      far_send(rows[i].d);
      poll(`ASER_ST_RECEIVE_FULL_FLAG);
      rd(`ASER_OFS_CTL1);
      chk_val({8'h00, rd_a[7]}, {8'h00, rows[i].nine & rows[i].d[8]});
      rd(`ASER_OFS_DATA);
      chk_val({1'b0, rd_a}, {1'b0, rows[i].d[7:0]});
      rd(`ASER_OFS_STAT);
      chk_val({8'h00, rd_a[5]}, 9'h000);
      end_test("row");
    end
    NINE <= 1'b0;
    wr(`ASER_OFS_CTL1, 8'h00);
    // Wire order: mid-bit samples of one frame
    wf = {1'b1, 8'h96, 1'b0};
    wr(`ASER_OFS_DATA, 8'h96);
    @(negedge link.dev_txd);
    repeat (8) @(posedge SYS_CLK);
    for (int i = 0; i < 10; i++)
    begin
      chk_val({8'h00, link.dev_txd}, {8'h00, wf[i]});
      repeat (16) @(posedge SYS_CLK);
    end
    end_test("wire");
    // Two characters with no read between
    far_send(9'h011);
    far_send(9'h022);
    poll(`ASER_ST_OVR);
    chk_val({1'b0, rd_a & 8'h2a}, 9'h028);
    rd(`ASER_OFS_DATA);
    chk_val({1'b0, rd_a}, 9'h011);
    rd(`ASER_OFS_STAT);
    chk_val({1'b0, rd_a & 8'h28}, 9'h000);
    end_test("overrun");
    wr(`ASER_OFS_CTL2, 8'h2c);
    far_send(9'h033);
    poll(`ASER_ST_RECEIVE_FULL_FLAG);
    chk_val({8'h00, IRQ}, 9'h001);
    rd(`ASER_OFS_DATA);
    repeat (3) @(posedge SYS_CLK);
    chk_val({8'h00, IRQ}, 9'h000);
    wr(`ASER_OFS_CTL2, 8'h8c);
    repeat (3) @(posedge SYS_CLK);
    chk_val({8'h00, IRQ}, 9'h001);
    wr(`ASER_OFS_CTL2, 8'h0c);
    repeat (3) @(posedge SYS_CLK);
    chk_val({8'h00, IRQ}, 9'h000);
    end_test("irq");
    line_send(8'h5a, 1'b1, 1'b1);
    rd(`ASER_OFS_STAT);
    chk_val({1'b0, rd_b & 8'h26}, 9'h024);
    rd(`ASER_OFS_DATA);
    line_send(8'h66, 1'b0, 1'b0);
    line_send(8'h77, 1'b0, 1'b1);
    rd(`ASER_OFS_STAT);
    chk_val({1'b0, rd_b & 8'h2a}, 9'h02a);
    rd(`ASER_OFS_DATA);
    chk_val({1'b0, rd_b}, 9'h066);
    rd(`ASER_OFS_STAT);
    chk_val({1'b0, rd_b & 8'h26}, 9'h000);
    end_test("faults");
    wr(`ASER_OFS_CTL2, 8'h0e);
    far_send(9'h044);
    repeat (200) @(posedge SYS_CLK);
    rd(`ASER_OFS_STAT);
    chk_val({8'h00, rd_a[5]}, 9'h000);
    repeat (300) @(posedge SYS_CLK);
    rd(`ASER_OFS_CTL2);
    chk_val({8'h00, rd_a[1]}, 9'h000);
    wr(`ASER_OFS_CTL2, 8'h0c);
    end_test("sleep");
    wr(`ASER_OFS_CTL2, 8'h0d);
    rd(`ASER_OFS_CTL2);
    chk_val({1'b0, rd_a}, 9'h00d);
    repeat (40) @(posedge SYS_CLK);
    rd(`ASER_OFS_STAT);
    wr(`ASER_OFS_DATA, 8'h00);
    rd(`ASER_OFS_STAT);
    chk_val({8'h00, rd_a[6]}, 9'h000);
    wr(`ASER_OFS_CTL2, 8'h0c);
    rx_far();
    chk_val({8'h00, RX_FRAME_ERR}, 9'h001);
    chk_val(RX_DATA, 9'h000);
    repeat (400) @(posedge SYS_CLK);
    rd(`ASER_OFS_STAT);
    chk_val({8'h00, rd_a[6]}, 9'h001);
    end_test("break");
    // Second reset in mid-run
    @(posedge SYS_CLK) RST <= 1'b1;
    repeat (10) @(posedge SYS_CLK);
    RST <= 1'b0;
    rd(`ASER_OFS_STAT);
    chk_val({1'b0, rd_a}, 9'h0c0);
    rd(`ASER_OFS_CTL2);
    chk_val({1'b0, rd_a}, 9'h000);
    rd(16'h1030);
    chk_val({1'b0, rd_a}, 9'h000);
    chk_val({7'h00, IRQ, link.dev_txd}, 9'h001);
    end_test("reset");
    complete_run();
  end
endmodule
